/* design/smbus_cfg_port.sv */
/*
 * SMBus target with indexed block write and block read of configuration
 * byte 0 (PLL mode and input source), address set by tri-level straps.
 * Assumes scl/sda already synchronous to clk_i and the bus wire resolved
 * outside from sda_oe_o; clk_i must oversample scl several times.
 */
// Contract
// R1: The device acknowledges a start followed by its own write address.
// R2: The index byte after the address is acknowledged and used as start.
// R3: In a write the byte count after the index is acknowledged.
// R4: Each of the X data bytes is acknowledged and stored consecutively.
// R5: The host ends a block write with a stop after the last data ack.
// R6: A read repeats start with the read address, which is acknowledged.
// R7: On a read the device sends the byte count, then bytes from index N.
// R8: The host acks each read byte, then not-acknowledge and stop.
// R9: The bus address comes from two tri-level straps, nine choices.
// R10: Byte 0 bits 7:6 and 5 read back the latched mode and source.
// R11: Bit 3 picks straps or register bits 2:0; bit 0 set means input A.
// R12: Bits 2 and 1 set PLL mode, reset to 1, effective under override.
// R13: Under override bits 7:5 still show the strap-latched values.
// R14: PLL mode 00 is low bandwidth, 01 bypass, 11 high bandwidth.
// R15: Reserved bits read zero; a foreign address gets not-acknowledge.
`timescale 1ns/1ps
module smbus_cfg_port #(
  parameter logic [7:0] RD_COUNT = smbus_cfg_pkg::RD_COUNT_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire smbus_cfg_pkg::straps_t straps_i,
  output logic [1:0] pll_mode_o,
  output logic ref_input_b_sel_o
);
  import smbus_cfg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ***************************************************************
  // Strap latch and effective controls
  // ***************************************************************
  logic latched_ff, nxt_latched;
  logic [7:0] own_addr_ff, nxt_own_addr;
  logic [1:0] strap_mode_ff, nxt_strap_mode;
  logic strap_src_ff, nxt_strap_src;
  logic [1:0] pll_mode_ff, nxt_pll_mode;
  logic src_b_ff, nxt_src_b;
  logic [3:0] ctrl_ff, nxt_ctrl;

  function automatic logic [1:0] tri_val(input logic [1:0] t);
    tri_val = (t == TRI_LOW) ? 2'h0 : (t == TRI_MID) ? 2'h1 : 2'h2;
  endfunction : tri_val
  function automatic logic [7:0] addr_lut(input straps_t s);
    logic [3:0] idx;
    idx = 4'({2'h0, tri_val(s.addr_hi)} * 4'h3) + {2'h0, tri_val(s.addr_lo)};
    addr_lut = ADDR_TABLE[idx*8 +: 8];
  endfunction : addr_lut
  function automatic logic [1:0] mode_lut(input logic [1:0] t);
    mode_lut = (t == TRI_LOW) ? PLL_LO_BW :
               (t == TRI_MID) ? PLL_BYPASS : PLL_HI_BW;
  endfunction : mode_lut

  always_comb begin
    nxt_latched = 1'b1;
    nxt_own_addr = own_addr_ff;
    nxt_strap_mode = strap_mode_ff;
    nxt_strap_src = strap_src_ff;
    // Straps are caught once, on the first edge after reset release
    if (!latched_ff) begin
      nxt_own_addr = addr_lut(straps_i); // see R9
      nxt_strap_mode = mode_lut(straps_i.pll_mode); // see R14
      nxt_strap_src = straps_i.input_b;
    end
    if (ctrl_ff[CFG0_OVR_BIT]) begin // see R11
      nxt_pll_mode = ctrl_ff[CFG0_MODE_LSB +: 2]; // see R12
      nxt_src_b = ~ctrl_ff[CFG0_SRC_BIT];
    end else begin
      nxt_pll_mode = nxt_strap_mode;
      nxt_src_b = nxt_strap_src;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched_ff <= 1'b0;
      own_addr_ff <= 8'h00;
      strap_mode_ff <= PLL_LO_BW;
      strap_src_ff <= 1'b0;
      pll_mode_ff <= PLL_LO_BW;
      src_b_ff <= 1'b0;
    end else begin
      latched_ff <= nxt_latched;
      own_addr_ff <= nxt_own_addr;
      strap_mode_ff <= nxt_strap_mode;
      strap_src_ff <= nxt_strap_src;
      pll_mode_ff <= nxt_pll_mode;
      src_b_ff <= nxt_src_b;
    end
  end

  // Bits 7:5 always show the strap values, reserved bit 4 reads zero
  logic [7:0] cfg0_rd;
  assign cfg0_rd = {strap_mode_ff, strap_src_ff, 1'b0, ctrl_ff}; // see R10 R13
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] rd_byte;
  assign rd_byte = (ptr_ff == CFG0_OFFSET) ? cfg0_rd : 8'h00; // see R15
  // ***************************************************************
  // Bus protocol engine
  // ***************************************************************
  port_state_t state_ff, nxt_state;
  logic [3:0] slot_ff, nxt_slot;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] cnt_ff, nxt_cnt;
  logic scl_q_ff, sda_q_ff;
  logic oe_ff, nxt_oe;

  logic scl_rise, scl_fall, bus_start, bus_stop, addr_hit, ack;
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign bus_start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign bus_stop = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign addr_hit = latched_ff && (shift_ff[7:1] == own_addr_ff[7:1]);
  always_comb begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_oe = oe_ff;
    nxt_ptr = ptr_ff;
    nxt_ctrl = ctrl_ff;
    ack = 1'b1;
    if (bus_start) begin // see R1, R6
      nxt_state = ST_ADDR;
      nxt_slot = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin // see R5, R8
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE, ST_IGNORE: begin
          nxt_oe = 1'b0;
        end
        ST_TX: begin // see R7
          if (scl_rise && slot_ff < SLOT_LAST) begin
            nxt_slot = slot_ff + 4'h1;
          end else if (scl_rise && slot_ff == SLOT_ACK) begin
            // Host not-acknowledge ends the read
            if (sda_i) begin // see R8
              nxt_state = ST_IGNORE;
            end else begin
              nxt_slot = SLOT_NEXT;
            end
          end else if (scl_fall && slot_ff == SLOT_LAST) begin
            nxt_oe = 1'b0;
            nxt_slot = SLOT_ACK;
          end else if (scl_fall && slot_ff == SLOT_NEXT) begin
            nxt_shift = rd_byte;
            nxt_oe = ~rd_byte[7];
            nxt_ptr = ptr_ff + 8'h01;
            nxt_slot = 4'h0;
          end else if (scl_fall && slot_ff inside {[4'h1:4'h7]}) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        default: begin
          if (scl_rise && slot_ff < SLOT_LAST) begin
            nxt_shift = {shift_ff[6:0], sda_i};
            nxt_slot = slot_ff + 4'h1;
          end else if (scl_fall && slot_ff == SLOT_LAST) begin
            if (state_ff == ST_ADDR) begin
              ack = addr_hit; // see R1, R6, R15
            end else if (state_ff == ST_INDEX) begin
              nxt_ptr = shift_ff; // see R2
            end else if (state_ff == ST_COUNT) begin
              nxt_cnt = shift_ff; // see R3
            end else begin
              // Bytes beyond the announced count are refused
              ack = (cnt_ff != 8'h00);
              if (ack) begin // see R4
                if (ptr_ff == CFG0_OFFSET) begin
                  nxt_ctrl = shift_ff[3:0]; // see R11, R12
                end
                nxt_ptr = ptr_ff + 8'h01;
                nxt_cnt = cnt_ff - 8'h01;
              end
            end
            nxt_oe = ack;
            nxt_slot = SLOT_ACK;
            if (!ack) begin
              nxt_state = ST_IGNORE;
            end
          end else if (scl_fall && slot_ff == SLOT_ACK) begin
            nxt_oe = 1'b0;
            nxt_slot = 4'h0;
            case (state_ff)
              ST_ADDR: begin
                if (shift_ff[0]) begin // see R7
                  nxt_state = ST_TX;
                  nxt_shift = RD_COUNT;
                  nxt_oe = ~RD_COUNT[7];
                end else begin
                  nxt_state = ST_INDEX;
                end
              end
              ST_INDEX: nxt_state = ST_COUNT;
              ST_COUNT: nxt_state = ST_WDATA;
              default: nxt_state = ST_WDATA;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_IDLE;
      slot_ff <= 4'h0;
      shift_ff <= 8'h00;
      cnt_ff <= 8'h00;
      oe_ff <= 1'b0;
      ptr_ff <= 8'h00;
      ctrl_ff <= CFG0_CTRL_RESET;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      oe_ff <= nxt_oe;
      ptr_ff <= nxt_ptr;
      ctrl_ff <= nxt_ctrl;
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // Open drain: the pad value is always low, only the enable moves
  assign sda_o = 1'b0 & oe_ff;
  assign sda_oe_o = oe_ff;
  assign pll_mode_o = pll_mode_ff;
  assign ref_input_b_sel_o = src_b_ff;

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic ack_edge;
  assign ack_edge = scl_fall && slot_ff == SLOT_LAST;

  property p_addr_ack;
    ack_edge && state_ff == ST_ADDR && addr_hit |=>
      oe_ff && slot_ff == SLOT_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("addr nack"); // see R1
  property p_addr_nack;
    ack_edge && state_ff == ST_ADDR && !addr_hit |=>
      !oe_ff && state_ff == ST_IGNORE;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("bad ack"); // see R15
  property p_index;
    ack_edge && state_ff == ST_INDEX |=> oe_ff && ptr_ff == $past(shift_ff);
  endproperty
  a_index: assert property (p_index) else $error("index lost"); // see R2
  property p_count;
    ack_edge && state_ff == ST_COUNT |=> oe_ff && cnt_ff == $past(shift_ff);
  endproperty
  a_count: assert property (p_count) else $error("count lost"); // see R3
  property p_wdata;
    ack_edge && state_ff == ST_WDATA && cnt_ff != 8'h00 |=>
      oe_ff && ptr_ff == $past(ptr_ff) + 8'h01;
  endproperty
  a_wdata: assert property (p_wdata) else $error("data lost"); // see R4
  property p_tx_count;
    $rose(state_ff == ST_TX) |-> shift_ff == RD_COUNT && oe_ff == ~RD_COUNT[7];
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("no count"); // see R7
  property p_hw_mode;
    latched_ff && !ctrl_ff[3] ##1 !ctrl_ff[3] |->
      pll_mode_o == strap_mode_ff && ref_input_b_sel_o == strap_src_ff;
  endproperty
  a_hw_mode: assert property (p_hw_mode) else $error("strap lost"); // see R11
  property p_sw_mode;
    ctrl_ff[3] |=> pll_mode_o == $past(ctrl_ff[2:1]) &&
      ref_input_b_sel_o == !$past(ctrl_ff[0]);
  endproperty
  a_sw_mode: assert property (p_sw_mode) else $error("no override"); // see R12
  property p_readback;
    state_ff == ST_TX && slot_ff == SLOT_NEXT && scl_fall &&
      ptr_ff == CFG0_OFFSET |=> shift_ff == {$past(strap_mode_ff),
      $past(strap_src_ff), 1'b0, $past(ctrl_ff)};
  endproperty
  a_readback: assert property (p_readback) else $error("readback"); // see R10

endmodule : smbus_cfg_port

/* design/smbus_cfg_pkg.sv */
/*
 * Constants and carrier types for the indexed block configuration port.
 * Assumes strap pins arrive already resolved to a three-level code.
 */
package smbus_cfg_pkg;

  // ***************************************************************
  // Tri-level strap encoding
  // ***************************************************************
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // Write-form bus address, entry i = high_strap * 3 + low_strap
  localparam logic [71:0] ADDR_TABLE = {8'hce, 8'hcc, 8'hca, 8'hc6,
    8'hc4, 8'hc2, 8'hde, 8'hda, 8'hd8};

  // ***************************************************************
  // PLL mode codes
  // ***************************************************************
  localparam logic [1:0] PLL_LO_BW = 2'h0;
  localparam logic [1:0] PLL_BYPASS = 2'h1;
  localparam logic [1:0] PLL_HI_BW = 2'h3;

  // ***************************************************************
  // Configuration byte 0 layout and reset
  // ***************************************************************
  localparam logic [7:0] CFG0_OFFSET = 8'h00;
  localparam int CFG0_MODE_RB_LSB = 6;
  localparam int CFG0_SRC_RB_BIT = 5;
  localparam int CFG0_OVR_BIT = 3;
  localparam int CFG0_MODE_LSB = 1;
  localparam int CFG0_SRC_BIT = 0;
  localparam logic [3:0] CFG0_CTRL_RESET = 4'h7;
  localparam logic [7:0] RD_COUNT_DEF = 8'h08;

  // ***************************************************************
  // Bit slot counts within one byte frame
  // ***************************************************************
  localparam logic [3:0] SLOT_LAST = 4'h8;
  localparam logic [3:0] SLOT_ACK = 4'h9;
  localparam logic [3:0] SLOT_NEXT = 4'ha;

  typedef struct packed {
    logic [1:0] addr_hi;
    logic [1:0] addr_lo;
    logic [1:0] pll_mode;
    logic input_b;
  } straps_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_TX, ST_IGNORE
  } port_state_t;

endpackage : smbus_cfg_pkg

/* tb/smbus_host_model.sv */
/*
 * Behavioural SMBus host controller driving the configuration port.
 * Assumes the bench resolves the open-drain SDA wire into sda_i.
 */
`timescale 1ns/1ps
module smbus_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ***************************************************************
  // Bit and byte level
  // ***************************************************************
  // Clocks per phase; the bench raises it to act as a slow host
  int unsigned half_clk = 8;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic half;
    repeat (half_clk) @(posedge clk_i);
    #1;
  endtask : half

  task automatic start_c;
    sda_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_o = 1'b0;
    half();
    scl_o = 1'b0;
    half();
  endtask : start_c

  task automatic stop_c;
    sda_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_o = 1'b1;
    half();
  endtask : stop_c

  // Data only moves one phase after scl falls, never on the fall
  task automatic bit_c(input logic v, output logic s);
    sda_o = v;
    half();
    scl_o = 1'b1;
    half();
    s = sda_i;
    scl_o = 1'b0;
    half();
  endtask : bit_c

  task automatic xfer(input logic [7:0] v, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      bit_c(v[i], s[i]);
    end
  endtask : xfer

  task automatic tx(input logic [7:0] b, output logic ack);
    logic [7:0] s;
    logic a;
    xfer(b, s);
    bit_c(1'b1, a);
    ack = ~a;
  endtask : tx

  task automatic rx(input logic hack, output logic [7:0] b);
    logic a;
    xfer(8'hff, b);
    bit_c(~hack, a);
  endtask : rx

  // ***************************************************************
  // Transactions
  // ***************************************************************
  task automatic probe(input logic [7:0] a, output logic ack);
    start_c();
    tx(a, ack);
    stop_c();
  endtask : probe

  task automatic wr(input logic [7:0] a, n, x, d0, d1, input int k,
                    output logic [4:0] acks);
    start_c();
    tx(a, acks[0]);
    tx(n, acks[1]);
    tx(x, acks[2]);
    tx(d0, acks[3]);
    acks[4] = 1'b0;
    if (k > 1) begin
      tx(d1, acks[4]);
    end
    stop_c();
  endtask : wr

  task automatic rd(input logic [7:0] a, n, input int k,
                    output logic [7:0] cnt, b0, b1,
                    output logic [2:0] acks);
    start_c();
    tx(a, acks[0]);
    tx(n, acks[1]);
    start_c();
    tx(a | 8'h01, acks[2]);
    rx(1'b1, cnt);
    rx(k > 1, b0);
    b1 = 8'h00;
    if (k > 1) begin
      rx(1'b0, b1);
    end
    stop_c();
  endtask : rd
endmodule : smbus_host_model

/* tb/tb.sv */
/*
 * Self-checking bench for the configuration port: host model on the bus.
 * Assumes an open-drain SDA with pull-up, resolved here.
 */
`timescale 1ns/1ps
module tb;
  import smbus_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic scl, host_sda, sda_o, sda_oe_o, sda_w;
  straps_t straps = '{2'h0, 2'h0, 2'h2, 1'b1};
  logic [1:0] pll_mode_o;
  logic ref_input_b_sel_o;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] addr_tab [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4,
    8'hc6, 8'hca, 8'hcc, 8'hce};
  logic [7:0] wd [3] = '{8'hfb, 8'h0e, 8'hf8};
  logic [7:0] wmode [3] = '{8'h01, 8'h03, 8'h00};
  logic [7:0] wsel [3] = '{8'h00, 8'h01, 8'h01};

  always #10 clk_i = ~clk_i;
  // Released wire reads the pull-up level
  assign sda_w = host_sda & ~(sda_oe_o & ~sda_o);

  smbus_cfg_port u_smbus_cfg_port (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .straps_i(straps),
    .pll_mode_o(pll_mode_o), .ref_input_b_sel_o(ref_input_b_sel_o));
  smbus_host_model u_smbus_host_model (
    .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic chk(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Straps are latched only after reset, so each address needs one
  task automatic do_reset(input logic [1:0] hi, lo);
    arst_n_i = 1'b0;
    straps.addr_hi = hi;
    straps.addr_lo = lo;
    repeat (6) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : do_reset

  function automatic logic [7:0] outs();
    return {5'h0, ref_input_b_sel_o, pll_mode_o};
  endfunction : outs

  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    logic [4:0] wa;
    logic [2:0] ra;
    logic [7:0] c, b0, b1;
    logic a;
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(i / 3), 2'(i % 3));
      u_smbus_host_model.probe(addr_tab[i], a);
      chk("own addr ack", {7'h0, a}, 8'h01);
      u_smbus_host_model.probe(addr_tab[(i + 1) % 9], a);
      chk("foreign addr", {7'h0, a}, 8'h00);
    end
    do_reset(2'h0, 2'h0);
    chk("strap outputs", outs(), 8'h07);
    u_smbus_host_model.rd(8'hd8, 8'h00, 1, c, b0, b1, ra);
    chk("read acks", {5'h0, ra}, 8'h07);
    chk("read count", c, RD_COUNT_DEF);
    chk("byte0 reset", b0, 8'he7);
    u_smbus_host_model.half_clk = 20;
    for (int j = 0; j < 3; j++) begin
      u_smbus_host_model.wr(8'hd8, 8'h00, 8'h01, wd[j], 8'h00, 1, wa);
      chk("write acks", {3'h0, wa}, 8'h0f);
      chk("mode out", {6'h0, pll_mode_o}, wmode[j]);
      chk("source out", {7'h0, ref_input_b_sel_o}, wsel[j]);
      u_smbus_host_model.rd(8'hd8, 8'h00, 1, c, b0, b1, ra);
      chk("byte0 back", b0, 8'he0 | (wd[j] & 8'h0f));
    end
    u_smbus_host_model.half_clk = 8;
    u_smbus_host_model.wr(8'hd8, 8'h00, 8'h02, 8'h0b, 8'h55, 2, wa);
    chk("two byte acks", {3'h0, wa}, 8'h1f);
    u_smbus_host_model.rd(8'hd8, 8'h00, 2, c, b0, b1, ra);
    chk("block byte0", b0, 8'heb);
    chk("block byte1", b1, 8'h00);
    u_smbus_host_model.wr(8'hd8, 8'h00, 8'h01, 8'h03, 8'h0f, 2, wa);
    chk("extra byte nack", {3'h0, wa}, 8'h0f);
    chk("back to straps", outs(), 8'h07);
    u_smbus_host_model.rd(8'hd8, 8'h00, 1, c, b0, b1, ra);
    chk("byte0 final", b0, 8'he3);
    straps.pll_mode = 2'h1;
    straps.input_b = 1'b0;
    do_reset(2'h2, 2'h2);
    chk("strap bypass", outs(), 8'h01);
    u_smbus_host_model.rd(8'hce, 8'h00, 1, c, b0, b1, ra);
    chk("bypass acks", {5'h0, ra}, 8'h07);
    chk("bypass byte0", b0, 8'h47);
    final_report();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
endmodule : tb
